// File: shared/dbg_trace_pkg.sv
// Shared types and constants for the trace encoder and debug bus share
package dbg_trace_pkg;

    // ------------------------------------------------------------------
    // Processor status codes
    // ------------------------------------------------------------------
    localparam logic [3:0] PST_CONT = 4'h0;
    localparam logic [3:0] PST_BASE = 4'h1;
    localparam logic [3:0] PST_TAKEN = 4'h5;
    localparam logic [3:0] PST_DATA1 = 4'h8;
    localparam logic [3:0] PST_DATA2 = 4'h9;
    localparam logic [3:0] PST_DATA3 = 4'ha;
    localparam logic [3:0] PST_DATA4 = 4'hb;

    // ------------------------------------------------------------------
    // Nibble counts per entry, reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] NIB_DATA1 = 4'h2;
    localparam logic [3:0] NIB_DATA2 = 4'h4;
    localparam logic [3:0] NIB_DATA3 = 4'h6;
    localparam logic [3:0] NIB_DATA4 = 4'h8;
    localparam logic [3:0] NIB_LAST = 4'h1;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Instruction classes, sizes, display modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CLS_REG_ONLY = 4'h0,
        CLS_COND_BRANCH = 4'h1,
        CLS_UNCOND_BRANCH = 4'h2,
        CLS_JUMP = 4'h3,
        CLS_BSR = 4'h4,
        CLS_BIT_CHANGE = 4'h5,
        CLS_RMW_LONG = 4'h6,
        CLS_SRC_LONG = 4'h7,
        CLS_SRC_WORD = 4'h8,
        CLS_CLEAR = 4'h9,
        CLS_BIT_TEST = 4'ha
    } instr_class_t;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } op_size_t;

    typedef enum logic [1:0] {
        SHOW_NONE = 2'h0,
        SHOW_READS = 2'h1,
        SHOW_WRITES = 2'h2,
        SHOW_BOTH = 2'h3
    } opnd_mode_t;

    typedef struct packed {
        instr_class_t cls;
        op_size_t size;
        logic src_mem;
        logic dst_mem;
        logic taken;
        logic [1:0] tgt_len;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] tgt;
    } retire_t;

    typedef struct packed {
        opnd_mode_t opnd_mode;
        logic branch_target_display;
        logic [3:0] breakpoint_status_field;
    } debug_config_status_t;

    typedef struct packed {
        logic vld;
        logic [3:0] code;
        logic [31:0] data;
    } entry_t;

    // ------------------------------------------------------------------
    // Background command kinds and local bus cycle
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_MEM_READ = 2'h0,
        CMD_MEM_WRITE = 2'h1,
        CMD_CPU_REG = 2'h2,
        CMD_CTRL_REG = 2'h3
    } cmd_kind_t;

    typedef struct packed {
        cmd_kind_t kind;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bdm_cmd_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic write;
    } bus_cycle_t;

endpackage : dbg_trace_pkg

// File: hw/dbg_bus_share.sv
// Background command sequencer sharing the processor local bus
`timescale 1ns/1ps
module dbg_bus_share (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_cpu_running,
    input wire logic i_cpu_dbg_write,
    input wire logic i_cmd_valid,
    input wire dbg_trace_pkg::bdm_cmd_t i_cmd,
    output logic o_cmd_ready,
    output logic o_cmd_done,
    output logic o_cmd_error,
    output logic [31:0] o_cmd_rdata,
    output logic o_bus_req,
    input wire logic i_bus_grant,
    output logic o_bus_valid,
    output dbg_trace_pkg::bus_cycle_t o_bus,
    input wire logic i_bus_done,
    input wire logic [31:0] i_bus_rdata
);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BS_IDLE = 2'h0,
        BS_REQ = 2'h1,
        BS_XFER = 2'h2
    } bus_state_t;

    bus_state_t state_reg, state_next;
    logic req_reg, req_next, vld_reg, vld_next;
    logic done_reg, done_next, err_reg, err_next;
    logic [31:0] rdata_reg, rdata_next;
    dbg_trace_pkg::bus_cycle_t bus_reg, bus_next;
    logic accept, is_mem;

    // Core writing debug registers: hold off commands
    assign accept = i_cmd_valid && state_reg == BS_IDLE && !i_cpu_dbg_write;
    assign is_mem = i_cmd.kind == dbg_trace_pkg::CMD_MEM_READ || i_cmd.kind == dbg_trace_pkg::CMD_MEM_WRITE;

    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        vld_next = vld_reg;
        done_next = 1'b0;
        err_next = 1'b0;
        rdata_next = rdata_reg;
        bus_next = bus_reg;
        case (state_reg)
            BS_IDLE: begin
                if (accept && is_mem) begin
                    req_next = 1'b1;
                    bus_next.addr = i_cmd.addr;
                    bus_next.wdata = i_cmd.wdata;
                    bus_next.write = i_cmd.kind == dbg_trace_pkg::CMD_MEM_WRITE;
                    state_next = BS_REQ;
                end else if (accept) begin
                    // Register paths of the core exist only while halted
                    done_next = 1'b1;
                    err_next = i_cpu_running;
                end
            end
            BS_REQ: begin
                // No timeout: a one-longword loop may never grant
                if (i_bus_grant) begin
                    vld_next = 1'b1;
                    state_next = BS_XFER;
                end
            end
            BS_XFER: begin
                if (i_bus_done) begin
                    vld_next = 1'b0;
                    req_next = 1'b0;
                    done_next = 1'b1;
                    rdata_next = bus_reg.write ? rdata_reg : i_bus_rdata;
                    state_next = BS_IDLE;
                end
            end
            default: begin
                state_next = BS_IDLE;
                req_next = 1'b0;
                vld_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_reg <= BS_IDLE;
            req_reg <= 1'b0;
            vld_reg <= 1'b0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= dbg_trace_pkg::RST_WORD;
            bus_reg <= '0;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            vld_reg <= vld_next;
            done_reg <= done_next;
            err_reg <= err_next;
            rdata_reg <= rdata_next;
            bus_reg <= bus_next;
        end
    end

    assign o_cmd_ready = state_reg == BS_IDLE && !i_cpu_dbg_write;
    assign o_cmd_done = done_reg;
    assign o_cmd_error = err_reg;
    assign o_cmd_rdata = rdata_reg;
    assign o_bus_req = req_reg;
    assign o_bus_valid = vld_reg;
    assign o_bus = bus_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_REG_REFUSED: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        accept && !is_mem && i_cpu_running |=> o_cmd_done && o_cmd_error)
        else $error("register command not refused while running");
    AST_MEM_REQUEST: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        accept && is_mem |=> o_bus_req && !o_bus_valid)
        else $error("memory command did not request the bus");
    AST_RELEASE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_bus_valid && i_bus_done |=> !o_bus_req && !o_bus_valid && o_cmd_done)
        else $error("bus not returned after the cycle");
    AST_CYCLE_AFTER_GRANT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_bus_valid) |-> $past(i_bus_grant) && o_bus_req)
        else $error("bus cycle started without grant");

endmodule : dbg_bus_share

// File: hw/dbg_trace_status.sv
// Status and debug data encoder with concurrent background bus sharing
`timescale 1ns/1ps
module dbg_trace_status (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_retire_valid,
    input wire dbg_trace_pkg::retire_t i_retire,
    output logic o_retire_ready,
    input wire dbg_trace_pkg::debug_config_status_t i_debug_config_status_reg,
    output logic [3:0] o_processor_status_code,
    output logic [3:0] o_debug_data_nibble,
    input wire logic i_cpu_running,
    input wire logic i_cpu_dbg_write,
    input wire logic i_cmd_valid,
    input wire dbg_trace_pkg::bdm_cmd_t i_cmd,
    output logic o_cmd_ready,
    output logic o_cmd_done,
    output logic o_cmd_error,
    output logic [31:0] o_cmd_rdata,
    output logic o_bus_req,
    input wire logic i_bus_grant,
    output logic o_bus_valid,
    output dbg_trace_pkg::bus_cycle_t o_bus,
    input wire logic i_bus_done,
    input wire logic [31:0] i_bus_rdata
);

    // ------------------------------------------------------------------
    // Background bus share
    // ------------------------------------------------------------------
    dbg_bus_share u_bus_share (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_cpu_running(i_cpu_running),
        .i_cpu_dbg_write(i_cpu_dbg_write),
        .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd),
        .o_cmd_ready(o_cmd_ready),
        .o_cmd_done(o_cmd_done),
        .o_cmd_error(o_cmd_error),
        .o_cmd_rdata(o_cmd_rdata),
        .o_bus_req(o_bus_req),
        .i_bus_grant(i_bus_grant),
        .o_bus_valid(o_bus_valid),
        .o_bus(o_bus),
        .i_bus_done(i_bus_done),
        .i_bus_rdata(i_bus_rdata)
    );

    // ------------------------------------------------------------------
    // Entry decode
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_HEAD = 2'h1,
        ST_BODY = 2'h2
    } trace_state_t;

    dbg_trace_pkg::debug_config_status_t cfg;
    logic show_rd, show_wr, accept;
    logic [3:0] base_code, size_code;
    dbg_trace_pkg::entry_t new0, new1, cand_a, cand_b;

    assign cfg = i_debug_config_status_reg;
    assign show_rd = cfg.opnd_mode == dbg_trace_pkg::SHOW_READS
        || cfg.opnd_mode == dbg_trace_pkg::SHOW_BOTH;
    assign show_wr = cfg.opnd_mode == dbg_trace_pkg::SHOW_WRITES
        || cfg.opnd_mode == dbg_trace_pkg::SHOW_BOTH;

    function automatic logic [3:0] nibbles_of(input logic [3:0] code);
        case (code)
            dbg_trace_pkg::PST_DATA1: nibbles_of = dbg_trace_pkg::NIB_DATA1;
            dbg_trace_pkg::PST_DATA2: nibbles_of = dbg_trace_pkg::NIB_DATA2;
            dbg_trace_pkg::PST_DATA3: nibbles_of = dbg_trace_pkg::NIB_DATA3;
            default: nibbles_of = dbg_trace_pkg::NIB_DATA4;
        endcase
    endfunction : nibbles_of

    always_comb begin
        case (i_retire.size)
            dbg_trace_pkg::SZ_BYTE: size_code = dbg_trace_pkg::PST_DATA1;
            dbg_trace_pkg::SZ_WORD: size_code = dbg_trace_pkg::PST_DATA2;
            default: size_code = dbg_trace_pkg::PST_DATA4;
        endcase
    end

    // Candidate A is the earlier entry, B the later; gaps are packed
    always_comb begin
        base_code = dbg_trace_pkg::PST_BASE;
        cand_a = '0;
        cand_b = '0;
        case (i_retire.cls)
            dbg_trace_pkg::CLS_REG_ONLY: begin
                base_code = dbg_trace_pkg::PST_BASE;
            end
            dbg_trace_pkg::CLS_COND_BRANCH: begin
                base_code = i_retire.taken ? dbg_trace_pkg::PST_TAKEN : dbg_trace_pkg::PST_BASE;
            end
            dbg_trace_pkg::CLS_UNCOND_BRANCH: begin
                base_code = dbg_trace_pkg::PST_TAKEN;
            end
            dbg_trace_pkg::CLS_JUMP: begin
                base_code = dbg_trace_pkg::PST_TAKEN;
                cand_a.vld = cfg.branch_target_display;
                cand_a.code = dbg_trace_pkg::PST_DATA2 + {2'h0, i_retire.tgt_len};
                cand_a.data = i_retire.tgt;
            end
            dbg_trace_pkg::CLS_BSR: begin
                base_code = dbg_trace_pkg::PST_TAKEN;
                cand_a.vld = show_wr && i_retire.dst_mem;
                cand_a.code = dbg_trace_pkg::PST_DATA4;
                cand_a.data = i_retire.dst;
            end
            dbg_trace_pkg::CLS_BIT_CHANGE: begin
                cand_a.vld = show_rd && i_retire.dst_mem;
                cand_a.code = dbg_trace_pkg::PST_DATA1;
                cand_a.data = i_retire.src;
                cand_b.vld = show_wr && i_retire.dst_mem;
                cand_b.code = dbg_trace_pkg::PST_DATA1;
                cand_b.data = i_retire.dst;
            end
            dbg_trace_pkg::CLS_RMW_LONG: begin
                cand_a.vld = show_rd && i_retire.dst_mem;
                cand_a.code = dbg_trace_pkg::PST_DATA4;
                cand_a.data = i_retire.src;
                cand_b.vld = show_wr && i_retire.dst_mem;
                cand_b.code = dbg_trace_pkg::PST_DATA4;
                cand_b.data = i_retire.dst;
            end
            dbg_trace_pkg::CLS_SRC_LONG: begin
                cand_a.vld = show_rd && i_retire.src_mem;
                cand_a.code = dbg_trace_pkg::PST_DATA4;
                cand_a.data = i_retire.src;
            end
            dbg_trace_pkg::CLS_SRC_WORD: begin
                cand_a.vld = show_rd && i_retire.src_mem;
                cand_a.code = dbg_trace_pkg::PST_DATA2;
                cand_a.data = i_retire.src;
            end
            dbg_trace_pkg::CLS_CLEAR: begin
                cand_a.vld = show_wr && i_retire.dst_mem;
                cand_a.code = size_code;
                cand_a.data = i_retire.dst;
            end
            dbg_trace_pkg::CLS_BIT_TEST: begin
                cand_a.vld = show_rd && i_retire.dst_mem;
                cand_a.code = dbg_trace_pkg::PST_DATA1;
                cand_a.data = i_retire.src;
            end
            default: begin
                base_code = dbg_trace_pkg::PST_BASE;
            end
        endcase
        new0 = cand_a.vld ? cand_a : cand_b;
        new1 = cand_a.vld ? cand_b : '0;
    end

    // ------------------------------------------------------------------
    // Output sequencer
    // ------------------------------------------------------------------
    trace_state_t state_reg, state_next;
    dbg_trace_pkg::entry_t e0_reg, e0_next, e1_reg, e1_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [3:0] pst_reg, pst_next, dd_reg, dd_next;
    logic ready_reg, ready_next;
    logic [3:0] bp_nibble;

    assign accept = i_retire_valid && ready_reg;
    // Status 0001/0010/0101/0110 maps to 0010/0100/1010/1100
    assign bp_nibble = {cfg.breakpoint_status_field[2:0], 1'b0};

    always_comb begin
        state_next = state_reg;
        e0_next = e0_reg;
        e1_next = e1_reg;
        cnt_next = cnt_reg;
        pst_next = dbg_trace_pkg::PST_CONT;
        dd_next = bp_nibble;
        ready_next = ready_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    pst_next = base_code;
                    e0_next = new0;
                    e1_next = new1;
                    if (new0.vld) begin
                        state_next = ST_HEAD;
                        ready_next = 1'b0;
                    end
                end
            end
            ST_HEAD: begin
                pst_next = e0_reg.code;
                dd_next = e0_reg.data[3:0];
                e0_next.data = {4'h0, e0_reg.data[31:4]};
                cnt_next = nibbles_of(e0_reg.code) - dbg_trace_pkg::NIB_LAST;
                state_next = ST_BODY;
            end
            ST_BODY: begin
                dd_next = e0_reg.data[3:0];
                e0_next.data = {4'h0, e0_reg.data[31:4]};
                cnt_next = cnt_reg - dbg_trace_pkg::NIB_LAST;
                if (cnt_reg == dbg_trace_pkg::NIB_LAST) begin
                    e0_next = e1_reg;
                    e1_next = '0;
                    if (e1_reg.vld) begin
                        state_next = ST_HEAD;
                    end else begin
                        state_next = ST_IDLE;
                        ready_next = 1'b1;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                ready_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            e0_reg <= '0;
            e1_reg <= '0;
            cnt_reg <= dbg_trace_pkg::RST_NIBBLE;
            pst_reg <= dbg_trace_pkg::PST_CONT;
            dd_reg <= dbg_trace_pkg::RST_NIBBLE;
            ready_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            e0_reg <= e0_next;
            e1_reg <= e1_next;
            cnt_reg <= cnt_next;
            pst_reg <= pst_next;
            dd_reg <= dd_next;
            ready_reg <= ready_next;
        end
    end

    assign o_processor_status_code = pst_reg;
    assign o_debug_data_nibble = dd_reg;
    assign o_retire_ready = ready_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_BASE_FIRST: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        accept && i_retire.cls == dbg_trace_pkg::CLS_REG_ONLY
        |=> o_processor_status_code == 4'h1 && o_retire_ready)
        else $error("register-only form not a lone 0x1");
    AST_COND_BRANCH: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        accept && i_retire.cls == dbg_trace_pkg::CLS_COND_BRANCH
        |=> o_processor_status_code == ($past(i_retire.taken) ? 4'h5 : 4'h1))
        else $error("conditional branch code wrong");
    AST_BRANCH_ONLY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        accept && i_retire.cls == dbg_trace_pkg::CLS_UNCOND_BRANCH
        |=> o_processor_status_code == 4'h5 && o_retire_ready)
        else $error("branch emitted more than 0x5");
    AST_REG_NO_DATA: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        accept && i_retire.cls == dbg_trace_pkg::CLS_SRC_LONG && !i_retire.src_mem
        |=> o_processor_status_code == 4'h1 && o_retire_ready)
        else $error("register operand produced an entry");
    AST_MODE_OFF: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        accept && cfg.opnd_mode == dbg_trace_pkg::SHOW_NONE && i_retire.cls != dbg_trace_pkg::CLS_JUMP
        |=> o_retire_ready)
        else $error("entry shown with display off");
    AST_LONG_ENTRY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        state_reg == ST_HEAD && e0_reg.code == 4'hb
        |=> o_processor_status_code == 4'hb ##1 (o_processor_status_code == 4'h0) [*7])
        else $error("4-byte entry not eight nibbles");
    AST_BYTE_ENTRY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        state_reg == ST_HEAD && e0_reg.code == 4'h8
        |=> o_processor_status_code == 4'h8 && o_debug_data_nibble == $past(e0_reg.data[3:0])
        ##1 o_processor_status_code == 4'h0 ##1 o_processor_status_code != 4'h0 || o_retire_ready)
        else $error("1-byte entry not two nibbles");
    AST_IDLE_STATUS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        state_reg == ST_IDLE
        |=> o_debug_data_nibble == {$past(cfg.breakpoint_status_field[2:0]), 1'b0})
        else $error("idle data port not breakpoint status");

endmodule : dbg_trace_status

// File: test/dbg_core_bus_model.sv
// Core-side local bus model answering debug bus requests
`timescale 1ns/1ps
module dbg_core_bus_model (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_bus_req,
    input wire logic i_bus_valid,
    input wire dbg_trace_pkg::bus_cycle_t i_bus,
    input wire logic i_hold,
    output logic o_bus_grant,
    output logic o_bus_done,
    output logic [31:0] o_bus_rdata
);
    // Hold mimics a tight loop in one longword: grant withheld
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_bus_grant <= 1'b0;
            o_bus_done <= 1'b0;
            o_bus_rdata <= 32'h0;
        end else begin
            o_bus_grant <= i_bus_req && !i_hold;
            o_bus_done <= i_bus_valid && !o_bus_done;
            // Idle data toggles so stale values never look valid
            o_bus_rdata <= (i_bus_valid && !o_bus_done) ? ~i_bus.addr : ~o_bus_rdata;
        end
    end
endmodule : dbg_core_bus_model

// File: test/debug_trace_status_and_bus_share_test.sv
// Self-checking bench for the trace encoder and debug bus share
`timescale 1ns/1ps
module debug_trace_status_and_bus_share_test;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, rv = 1'b0, run = 1'b0, dw = 1'b0, cv = 1'b0, hold = 1'b0;
    logic rdy, crdy, done, err, breq, bval, gnt, bdone;
    logic [3:0] processor_status_code, dnib;
    logic [31:0] crd, brd, last = 32'h0, a;
    dbg_trace_pkg::retire_t ret = '0, r;
    dbg_trace_pkg::debug_config_status_t cfg = '0;
    dbg_trace_pkg::bdm_cmd_t cmd = '0;
    dbg_trace_pkg::bus_cycle_t bus;
    int num_errors = 0, n_checks = 0, cycles = 0;
    integer seed = 32'hb8b23be6;
    logic [7:0] q[$];
    always #5 i_mclk = ~i_mclk;
    dbg_trace_status u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_retire_valid(rv), .i_retire(ret),
        .o_retire_ready(rdy), .i_debug_config_status_reg(cfg), .o_processor_status_code(processor_status_code),
        .o_debug_data_nibble(dnib), .i_cpu_running(run), .i_cpu_dbg_write(dw), .i_cmd_valid(cv), .i_cmd(cmd),
        .o_cmd_ready(crdy), .o_cmd_done(done), .o_cmd_error(err), .o_cmd_rdata(crd), .o_bus_req(breq),
        .i_bus_grant(gnt), .o_bus_valid(bval), .o_bus(bus), .i_bus_done(bdone), .i_bus_rdata(brd));
    dbg_core_bus_model u_core (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus_req(breq), .i_bus_valid(bval),
        .i_bus(bus), .i_hold(hold), .o_bus_grant(gnt), .o_bus_done(bdone), .o_bus_rdata(brd));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    function automatic void push(input logic [3:0] c, input int n, input logic [31:0] v);
        for (int i = 0; i < n; i++) q.push_back({i == 0 ? c : 4'h0, v[4*i+:4]});
    endfunction : push
    task automatic retire(input logic [1:0] m);
        logic [3:0] bs;
        logic btd, flow, rd_b, wr_b;
        bs = 4'($random(seed));
        btd = 1'($random(seed));
        rd_b = m[0] && r.dst_mem;
        wr_b = m[1] && r.dst_mem;
        flow = r.cls inside {dbg_trace_pkg::CLS_UNCOND_BRANCH, dbg_trace_pkg::CLS_JUMP, dbg_trace_pkg::CLS_BSR};
        flow = flow || (r.cls == dbg_trace_pkg::CLS_COND_BRANCH && r.taken);
        q = {};
        q.push_back({flow ? 4'h5 : 4'h1, bs[2:0], 1'b0});
        if (btd && r.cls == dbg_trace_pkg::CLS_JUMP) push(4'h9 + 4'(r.tgt_len), 4 + 2 * r.tgt_len, r.tgt);
        if (wr_b && r.cls == dbg_trace_pkg::CLS_BSR) push(4'hb, 8, r.dst);
        if (rd_b && r.cls == dbg_trace_pkg::CLS_BIT_CHANGE) push(4'h8, 2, r.src);
        if (wr_b && r.cls == dbg_trace_pkg::CLS_BIT_CHANGE) push(4'h8, 2, r.dst);
        if (rd_b && r.cls == dbg_trace_pkg::CLS_BIT_TEST) push(4'h8, 2, r.src);
        if (m[0] && r.src_mem && r.cls == dbg_trace_pkg::CLS_SRC_LONG) push(4'hb, 8, r.src);
        if (m[0] && r.src_mem && r.cls == dbg_trace_pkg::CLS_SRC_WORD) push(4'h9, 4, r.src);
        if (rd_b && r.cls == dbg_trace_pkg::CLS_RMW_LONG) push(4'hb, 8, r.src);
        if (wr_b && r.cls == dbg_trace_pkg::CLS_RMW_LONG) push(4'hb, 8, r.dst);
        if (wr_b && r.cls == dbg_trace_pkg::CLS_CLEAR)
            push(r.size == dbg_trace_pkg::SZ_LONG ? 4'hb : 4'h8 + 4'(r.size), 2 << r.size, r.dst);
        q.push_back({4'h0, bs[2:0], 1'b0});
        @(posedge i_mclk);
        ret <= r;
        // Breakpoint setup only loads between instructions, triggers idle
        cfg <= '{opnd_mode: dbg_trace_pkg::opnd_mode_t'(m), branch_target_display: btd, breakpoint_status_field: bs};
        rv <= 1'b1;
        #1;
        for (int j = 0; j < 40 && rdy !== 1'b1; j++) begin @(posedge i_mclk); #1; end
        @(posedge i_mclk);
        rv <= 1'b0;
        foreach (q[k]) begin
            #1;
            check("status code", processor_status_code, q[k][7:4]);
            check("data nibble", dnib, q[k][3:0]);
            @(posedge i_mclk);
        end
    endtask : retire
    task automatic command(input logic [1:0] k, input logic e_err);
        @(posedge i_mclk);
        cmd <= '{kind: dbg_trace_pkg::cmd_kind_t'(k), addr: a, wdata: ~a};
        cv <= 1'b1;
        #1;
        for (int j = 0; j < 20 && crdy !== 1'b1; j++) begin @(posedge i_mclk); #1; end
        @(posedge i_mclk);
        cv <= 1'b0;
        #1;
        for (int j = 0; j < 60 && done !== 1'b1; j++) begin @(posedge i_mclk); #1; end
        if (k == 2'h0) last = ~a;
        check("done", done, 1'b1);
        check("error", err, e_err);
        check("read data", crd, last);
        check("bus request", breq, 1'b0);
        if (k < 2'h2) begin
            check("bus address", bus.addr, a);
            check("bus write data", bus.wdata, ~a);
            check("bus direction", bus.write, k[0]);
        end
    endtask : command
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        #1;
        check("reset status", processor_status_code, 4'h0);
        check("reset data", dnib, 4'h0);
        check("reset handshakes", {rdy, crdy, breq, bval, done, err}, 6'h30);
        for (int i = 0; i < 60; i++) begin
            r = '0;
            r.cls = dbg_trace_pkg::instr_class_t'(i < 11 ? i : $unsigned($random(seed)) % 11);
            r.size = dbg_trace_pkg::op_size_t'($unsigned($random(seed)) % 3);
            r.tgt_len = 2'($unsigned($random(seed)) % 3);
            r.tgt = $random(seed);
            r.src_mem = i < 12 ? 1'b1 : 1'($random(seed));
            r.dst_mem = i < 12 ? 1'b1 : 1'($random(seed));
            r.taken = 1'($random(seed));
            r.src = $random(seed);
            r.dst = $random(seed);
            retire(i < 12 ? 2'(i) : 2'($random(seed)));
        end
        $display("trace test done");
        for (int i = 0; i < 8; i++) begin
            @(posedge i_mclk);
            run <= i[2];
            a = $random(seed);
            command(i[1:0], i[1] & i[2]);
        end
        @(posedge i_mclk);
        hold <= 1'b1;
        fork
            command(2'h0, 1'b0);
            begin
                repeat (30) @(posedge i_mclk);
                #1;
                check("held bus cycle", bval, 1'b0);
                check("request while held", breq, 1'b1);
                @(posedge i_mclk);
                hold <= 1'b0;
            end
        join
        @(posedge i_mclk);
        dw <= 1'b1;
        @(posedge i_mclk);
        #1;
        check("ready while core writes", crdy, 1'b0);
        @(posedge i_mclk);
        dw <= 1'b0;
        $display("command test done");
        complete_run();
    end
endmodule : debug_trace_status_and_bus_share_test
